// ===== pkg/fisr_pkg.sv
// Purpose : Shared constants and carriers for the fault interrupt status block.
// Assumes : 32-bit AHB-Lite register bus, one word per register.
// Notes   : Printed offsets are word indices; byte address is four times the index.
`default_nettype none
package fisr_pkg;

  localparam int          REG_W          = 8;
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 32;
  localparam int          IDX_W          = 10;

  // Word indices; byte address = index * 4
  localparam logic [9:0]  IDX_SEVERE     = 10'h068;
  localparam logic [9:0]  IDX_SUMMARY    = 10'h069;
  localparam logic [9:0]  IDX_LINK       = 10'h06a;
  localparam logic [9:0]  IDX_LIVE       = 10'h06c;
  localparam logic [9:0]  IDX_EVT_STAT   = 10'h06d;
  localparam logic [9:0]  IDX_EVT_MASK   = 10'h06e;

  localparam logic [7:0]  REG_RST        = 8'h00;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  // Severe-fault register fields
  localparam int          SEV_THERM_BIT  = 0;
  localparam int          SEV_OVP_BIT    = 1;
  localparam int          SEV_SEQ_BIT    = 2;
  localparam logic [7:0]  SEV_W1C_MASK   = 8'h07;

  // Summary register fields
  localparam int          SUM_IMM_BIT    = 0;
  localparam int          SUM_ORD_BIT    = 1;
  localparam int          SUM_MCU_BIT    = 2;
  localparam int          SUM_SOC_BIT    = 3;
  localparam int          SUM_LINK_BIT   = 4;
  localparam int          SUM_RDBK_BIT   = 5;
  localparam int          SUM_MON_BIT    = 6;
  localparam int          SUM_WD_BIT     = 7;
  localparam logic [7:0]  SUM_W1C_MASK   = 8'h0f;

  // Link fault register fields
  localparam int          LNK_FRM_BIT    = 0;
  localparam int          LNK_CRC_BIT    = 1;
  localparam int          LNK_ADR_BIT    = 3;
  localparam int          LNK_CRC2_BIT   = 5;
  localparam int          LNK_ADR2_BIT   = 7;
  localparam logic [7:0]  LNK_W1C_MASK   = 8'hab;

  // Live status fields
  localparam int          LIVE_THERM_BIT = 0;

  // Event status and mask fields
  localparam int          EVT_SEVERE_BIT = 0;
  localparam int          EVT_RAIL_BIT   = 1;
  localparam int          EVT_LINK_BIT   = 2;
  localparam int          EVT_RDBK_BIT   = 3;
  localparam int          EVT_MON_BIT    = 4;
  localparam int          EVT_WD_BIT     = 5;
  localparam logic [7:0]  EVT_USED_MASK  = 8'h3f;

  localparam int          HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;

  typedef struct packed {
    logic seq_err;
    logic overvoltage;
    logic thermal_hot;
    logic soc_rail_err;
    logic mcu_rail_err;
    logic orderly_off;
    logic immediate_off;
  } fisr_fault_evt_type;

  typedef struct packed {
    logic frame_err;
    logic crc_err;
    logic addr_err;
    logic crc2_err;
    logic addr2_err;
  } fisr_link_evt_type;

  typedef struct packed {
    logic reset_flag;
    logic fail_flag;
    logic long_window_flag;
  } fisr_wd_flags_type;

endpackage
`default_nettype wire

// ===== hw/fisr_top.sv
// Purpose : Latched fault status, summary mirrors, link faults and interrupt outputs.
// Assumes : Fault inputs are synchronous levels; a high level sets its flag every cycle.
// Notes   : Zero-wait AHB-Lite slave; unmapped addresses read zero and ignore writes.
//
// Functional notes
// - Sequencer error sets severe bit 2, held until software clears it.
// - Input over-voltage sets severe bit 1 and forces all regulators off.
// - Thermal immediate shutdown sets severe bit 0, forces regulators off and blocks enabling while set.
// - The live thermal condition is readable in a separate non-latched status bit.
// - Summary bit 7 is read-only and mirrors any pending watchdog reset, fail or long-window flag.
// - Summary bit 6 is read-only and is set while the signal monitor register is non-zero.
// - Summary bit 5 is read-only and is set while the read-back fault register is non-zero.
// - Summary bit 4 is read-only and is set while the link fault register is non-zero.
// - SoC rail power error latches summary bit 3 until cleared.
// - MCU rail power error latches summary bit 2 until cleared.
// - An orderly shutdown latches summary bit 1 until cleared.
// - An immediate shutdown latches summary bit 0 until cleared.
// - Writing 1 clears a latched bit, writing 0 keeps it, and read-only bits ignore writes.
// - Severe register at index 0x68 and summary at the next index, both resetting to zero.
// - Link fault register latches framing, CRC and address flags that clear by writing 1.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module fisr_top
(
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        hsel,
  input  wire logic [fisr_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [fisr_pkg::DATA_W-1:0] hwdata,
  input  wire logic                        hready,
  output var  logic                        hreadyout,
  output var  logic [fisr_pkg::DATA_W-1:0] hrdata,
  output var  logic                        hresp,
  input  wire fisr_pkg::fisr_fault_evt_type fault_evt,
  input  wire fisr_pkg::fisr_link_evt_type  link_evt,
  input  wire fisr_pkg::fisr_wd_flags_type  wd_flags,
  input  wire logic [fisr_pkg::REG_W-1:0]  signal_monitor_fault_reg,
  input  wire logic [fisr_pkg::REG_W-1:0]  readback_fault_reg,
  input  wire logic                        regulator_enable_req,
  output var  logic                        regulator_enable,
  output var  logic                        interrupt_out_n,
  output var  logic                        irq
);
  import fisr_pkg::*;

  // Bus state
  logic                 hreadyout_ff;
  logic [DATA_W-1:0]    hrdata_ff;
  logic                 hresp_ff;
  logic                 wr_pend_ff;
  logic [IDX_W-1:0]     wr_idx_ff;

  // Register state
  logic [REG_W-1:0]     severe_ff;
  logic [REG_W-1:0]     summary_lat_ff;
  logic [REG_W-1:0]     link_ff;
  logic [REG_W-1:0]     mirror_ff;
  logic                 live_therm_ff;
  logic [REG_W-1:0]     evt_stat_ff;
  logic [REG_W-1:0]     evt_mask_ff;
  logic                 off_hold_ff;
  logic                 regulator_enable_ff;
  logic                 interrupt_out_n_ff;
  logic                 irq_ff;

  // Next values
  logic [REG_W-1:0]     nxt_severe;
  logic [REG_W-1:0]     nxt_summary_lat;
  logic [REG_W-1:0]     nxt_link;
  logic [REG_W-1:0]     nxt_mirror;
  logic [REG_W-1:0]     nxt_evt_stat;
  logic [REG_W-1:0]     nxt_evt_mask;
  logic                 nxt_off_hold;
  logic                 nxt_regulator_enable;
  logic                 nxt_interrupt_out_n;
  logic                 nxt_irq;
  logic [DATA_W-1:0]    nxt_hrdata;

  // Bus decode
  wire                  addr_phase   = hsel & htrans[HTRANS_ACT_BIT] & hready;
  wire                  rd_take      = addr_phase & ~hwrite;
  wire                  wr_take      = addr_phase & hwrite;
  wire [IDX_W-1:0]      ap_idx       = haddr[IDX_W+1:2];
  wire [REG_W-1:0]      wdata        = hwdata[REG_W-1:0];

  wire                  wr_severe    = wr_pend_ff & (wr_idx_ff == IDX_SEVERE);
  wire                  wr_summary   = wr_pend_ff & (wr_idx_ff == IDX_SUMMARY);
  wire                  wr_link      = wr_pend_ff & (wr_idx_ff == IDX_LINK);
  wire                  wr_mask      = wr_pend_ff & (wr_idx_ff == IDX_EVT_MASK);
  wire                  rd_evt_stat  = rd_take & (ap_idx == IDX_EVT_STAT);

  // Clear strobes, limited to write-one-to-clear positions
  wire [REG_W-1:0]      clr_severe   = wr_severe  ? (wdata & SEV_W1C_MASK) : ZERO_BYTE;
  wire [REG_W-1:0]      clr_summary  = wr_summary ? (wdata & SUM_W1C_MASK) : ZERO_BYTE;
  wire [REG_W-1:0]      clr_link     = wr_link    ? (wdata & LNK_W1C_MASK) : ZERO_BYTE;

  // Set terms
  logic [REG_W-1:0]     set_severe;
  logic [REG_W-1:0]     set_summary;
  logic [REG_W-1:0]     set_link;
  logic [REG_W-1:0]     evt_set;
  logic [REG_W-1:0]     level_vec;

  wire                  hard_off     = fault_evt.overvoltage | fault_evt.thermal_hot;

  always_comb
  begin
    set_severe                = ZERO_BYTE;
    set_severe[SEV_SEQ_BIT]   = fault_evt.seq_err;
    set_severe[SEV_OVP_BIT]   = fault_evt.overvoltage;
    set_severe[SEV_THERM_BIT] = fault_evt.thermal_hot;
  end

  always_comb
  begin
    set_summary               = ZERO_BYTE;
    set_summary[SUM_SOC_BIT]  = fault_evt.soc_rail_err;
    set_summary[SUM_MCU_BIT]  = fault_evt.mcu_rail_err;
    set_summary[SUM_ORD_BIT]  = fault_evt.orderly_off;
    // Over-voltage and thermal trips are immediate shutdowns too
    set_summary[SUM_IMM_BIT]  = fault_evt.immediate_off | hard_off;
  end

  always_comb
  begin
    set_link                  = ZERO_BYTE;
    set_link[LNK_FRM_BIT]     = link_evt.frame_err;
    set_link[LNK_CRC_BIT]     = link_evt.crc_err;
    set_link[LNK_ADR_BIT]     = link_evt.addr_err;
    set_link[LNK_CRC2_BIT]    = link_evt.crc2_err;
    set_link[LNK_ADR2_BIT]    = link_evt.addr2_err;
  end

  // Set wins over a clear in the same cycle
  assign nxt_severe      = ((severe_ff & ~clr_severe) | set_severe) & SEV_W1C_MASK;
  assign nxt_summary_lat = ((summary_lat_ff & ~clr_summary) | set_summary) & SUM_W1C_MASK;
  assign nxt_link        = ((link_ff & ~clr_link) | set_link) & LNK_W1C_MASK;

  // Read-only mirrors follow their sources; writes never reach them
  always_comb
  begin
    nxt_mirror               = ZERO_BYTE;
    nxt_mirror[SUM_WD_BIT]   = wd_flags.reset_flag | wd_flags.fail_flag | wd_flags.long_window_flag;
    nxt_mirror[SUM_MON_BIT]  = |signal_monitor_fault_reg;
    nxt_mirror[SUM_RDBK_BIT] = |readback_fault_reg;
    nxt_mirror[SUM_LINK_BIT] = |nxt_link;
  end

  // Class levels for the interrupt_out_n output, one bit per event class
  always_comb
  begin
    level_vec                 = ZERO_BYTE;
    level_vec[EVT_SEVERE_BIT] = |severe_ff;
    level_vec[EVT_RAIL_BIT]   = |summary_lat_ff;
    level_vec[EVT_LINK_BIT]   = mirror_ff[SUM_LINK_BIT];
    level_vec[EVT_RDBK_BIT]   = mirror_ff[SUM_RDBK_BIT];
    level_vec[EVT_MON_BIT]    = mirror_ff[SUM_MON_BIT];
    level_vec[EVT_WD_BIT]     = mirror_ff[SUM_WD_BIT];
  end

  // A class event is a bit newly going high in its register
  always_comb
  begin
    evt_set                 = ZERO_BYTE;
    evt_set[EVT_SEVERE_BIT] = |(nxt_severe & ~severe_ff);
    evt_set[EVT_RAIL_BIT]   = |(nxt_summary_lat & ~summary_lat_ff);
    evt_set[EVT_LINK_BIT]   = |(nxt_link & ~link_ff);
    evt_set[EVT_RDBK_BIT]   = nxt_mirror[SUM_RDBK_BIT] & ~mirror_ff[SUM_RDBK_BIT];
    evt_set[EVT_MON_BIT]    = nxt_mirror[SUM_MON_BIT] & ~mirror_ff[SUM_MON_BIT];
    evt_set[EVT_WD_BIT]     = nxt_mirror[SUM_WD_BIT] & ~mirror_ff[SUM_WD_BIT];
  end

  // Read clears the event status; a new event in that cycle survives
  wire [REG_W-1:0]      evt_keep     = rd_evt_stat ? ZERO_BYTE : evt_stat_ff;
  assign nxt_evt_stat = (evt_keep | evt_set) & EVT_USED_MASK;
  assign nxt_evt_mask = wr_mask ? (wdata & EVT_USED_MASK) : evt_mask_ff;

  assign nxt_irq             = |(nxt_evt_stat & evt_mask_ff);
  // Level output tracks the fault bits themselves, not the read-clear events
  assign nxt_interrupt_out_n = ~(|(level_vec & evt_mask_ff));

  // Trip holds regulators off until the enable request is withdrawn
  assign nxt_off_hold = hard_off | (off_hold_ff & regulator_enable_req);
  assign nxt_regulator_enable = regulator_enable_req & ~nxt_off_hold
                              & ~nxt_severe[SEV_THERM_BIT];

  // Read mux, captured in the address phase
  wire [REG_W-1:0]      sum_view     = mirror_ff | summary_lat_ff;
  wire [REG_W-1:0]      live_view    = {{(REG_W-1){1'b0}}, live_therm_ff};
  wire [REG_W-1:0]      rd_byte      = (ap_idx == IDX_SEVERE)   ? severe_ff   :
                                       (ap_idx == IDX_SUMMARY)  ? sum_view    :
                                       (ap_idx == IDX_LINK)     ? link_ff     :
                                       (ap_idx == IDX_LIVE)     ? live_view   :
                                       (ap_idx == IDX_EVT_STAT) ? evt_stat_ff :
                                       (ap_idx == IDX_EVT_MASK) ? evt_mask_ff :
                                                                  ZERO_BYTE;
  assign nxt_hrdata = rd_take ? {{(DATA_W-REG_W){1'b0}}, rd_byte} : hrdata_ff;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= HRESP_OKAY;
      hrdata_ff    <= '0;
      wr_pend_ff   <= 1'b0;
      wr_idx_ff    <= '0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= HRESP_OKAY;
      hrdata_ff    <= nxt_hrdata;
      wr_pend_ff   <= wr_take;
      wr_idx_ff    <= wr_take ? ap_idx : wr_idx_ff;
    end
  end

  // Fault registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      severe_ff      <= REG_RST;
      summary_lat_ff <= REG_RST;
      link_ff        <= REG_RST;
      mirror_ff      <= REG_RST;
      live_therm_ff  <= 1'b0;
    end
    else
    begin
      severe_ff      <= nxt_severe;
      summary_lat_ff <= nxt_summary_lat;
      link_ff        <= nxt_link;
      mirror_ff      <= nxt_mirror;
      live_therm_ff  <= fault_evt.thermal_hot;
    end
  end

  // Interrupt and regulator control
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      evt_stat_ff         <= REG_RST;
      evt_mask_ff         <= MASK_RST;
      off_hold_ff         <= 1'b0;
      regulator_enable_ff <= 1'b0;
      interrupt_out_n_ff  <= 1'b1;
      irq_ff              <= 1'b0;
    end
    else
    begin
      evt_stat_ff         <= nxt_evt_stat;
      evt_mask_ff         <= nxt_evt_mask;
      off_hold_ff         <= nxt_off_hold;
      regulator_enable_ff <= nxt_regulator_enable;
      interrupt_out_n_ff  <= nxt_interrupt_out_n;
      irq_ff              <= nxt_irq;
    end
  end

  assign hreadyout        = hreadyout_ff;
  assign hrdata           = hrdata_ff;
  assign hresp            = hresp_ff;
  assign regulator_enable = regulator_enable_ff;
  assign interrupt_out_n  = interrupt_out_n_ff;
  assign irq              = irq_ff;

  // hsize is accepted for any value; only the low byte of a word carries data
  wire                  unused_ok    = &{1'b0, hsize, hwdata[DATA_W-1:REG_W], haddr[ADDR_W-1:IDX_W+2], haddr[1:0]};

endmodule
`default_nettype wire

// ===== testbench/fisr_props.sv
// Purpose : Port-level checks for the fault interrupt status block.
// Assumes : Zero-wait slave; hrdata loads at the read address phase edge.
// Notes   : Summary mirrors lag their sources by one cycle.
`timescale 1ns/100ps
`default_nettype none
module fisr_props
  import fisr_pkg::*;
(
  input  wire logic                fisr_pkg_dummy_unused_n,
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic                hready,
  input  wire logic [31:0]         hrdata,
  input  wire fisr_fault_evt_type  fault_evt,
  input  wire fisr_wd_flags_type   wd_flags,
  input  wire logic [7:0]          signal_monitor_fault_reg,
  input  wire logic [7:0]          readback_fault_reg,
  input  wire logic                regulator_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Read address phase accepted by the slave
  wire logic rd_act = hsel & htrans[HTRANS_ACT_BIT] & hready & ~hwrite;
  wire logic rd_sev = rd_act & (haddr[11:2] == IDX_SEVERE);
  wire logic rd_sum = rd_act & (haddr[11:2] == IDX_SUMMARY);

  property p_seq;
    rd_sev && $past(rstn) && $past(fault_evt.seq_err) |=> hrdata[SEV_SEQ_BIT];
  endproperty
  a_seq: assert property (p_seq) else $error("sequencer flag missing");
  property p_ovp;
    fault_evt.overvoltage |-> ##1 !regulator_enable;
  endproperty
  a_ovp: assert property (p_ovp) else $error("regulators on after overvoltage");
  property p_therm;
    fault_evt.thermal_hot |=> !regulator_enable;
  endproperty
  a_therm: assert property (p_therm) else $error("regulators on after thermal trip");
  property p_wd;
    rd_sum && $past(rstn) |=> hrdata[SUM_WD_BIT] == $past(|wd_flags, 2);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog mirror wrong");
  property p_mon;
    rd_sum && $past(rstn) |=> hrdata[SUM_MON_BIT] == $past(|signal_monitor_fault_reg, 2);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor mirror wrong");
  property p_rdbk;
    rd_sum && $past(rstn) |=> hrdata[SUM_RDBK_BIT] == $past(|readback_fault_reg, 2);
  endproperty
  a_rdbk: assert property (p_rdbk) else $error("read-back mirror wrong");
  property p_soc;
    rd_sum && $past(rstn) && $past(fault_evt.soc_rail_err) |=> hrdata[SUM_SOC_BIT];
  endproperty
  a_soc: assert property (p_soc) else $error("soc rail flag missing");
  property p_imm;
    rd_sum && $past(rstn) && $past(fault_evt.immediate_off) |=> hrdata[SUM_IMM_BIT];
  endproperty
  a_imm: assert property (p_imm) else $error("immediate off flag missing");
endmodule

bind fisr_top fisr_props u_props
(
  .fisr_pkg_dummy_unused_n(1'b1), .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .fault_evt(fault_evt), .wd_flags(wd_flags),
  .signal_monitor_fault_reg(signal_monitor_fault_reg), .readback_fault_reg(readback_fault_reg),
  .regulator_enable(regulator_enable)
);
`default_nettype wire

// ===== testbench/fisr_host.sv
// Purpose : Host processor model issuing AHB-Lite single word transfers.
// Assumes : One slave whose hreadyout is the bus hready.
// Notes   : Waits on hready without a limit; the bench timeout ends a hang.
`timescale 1ns/100ps
`default_nettype none
module fisr_host
(
  input  wire logic        mclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

  task automatic xfer(input logic [9:0] idx, input logic is_wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, idx, 2'h0};
    hwrite <= is_wr;
    hsize  <= 3'h2;
    // Stale write data is scrambled so it never looks valid
    hwdata <= ~hwdata;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= is_wr ? d : ~d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose : Self-checking bench for the fault interrupt status block.
// Assumes : Host model owns the bus; fault sources are driven here.
// Notes   : Expected values come from the register layout only.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fisr_pkg::*;
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  logic               hsel, hwrite, hready, hresp, irq, interrupt_out_n, regulator_enable;
  logic               regulator_enable_req = 1'b0;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [7:0]         signal_monitor_fault_reg = 8'h0;
  logic [7:0]         readback_fault_reg = 8'h0;
  fisr_fault_evt_type fault_evt = '0;
  fisr_link_evt_type  link_evt = '0;
  fisr_wd_flags_type  wd_flags = '0;
  int                 err_count = 0;
  int                 checked = 0;
  int                 cyc = 0;

  fisr_top dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .fault_evt(fault_evt), .link_evt(link_evt), .wd_flags(wd_flags),
    .signal_monitor_fault_reg(signal_monitor_fault_reg), .readback_fault_reg(readback_fault_reg),
    .regulator_enable_req(regulator_enable_req), .regulator_enable(regulator_enable),
    .interrupt_out_n(interrupt_out_n), .irq(irq));
  fisr_host host (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  always #2.5 mclk = ~mclk;

  task automatic finish_test();
    $display("Mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] want);
    logic [31:0] q;
    host.xfer(idx, 1'b0, 32'h0, q);
    chk(q, want);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(idx, 1'b1, d, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic fpulse(input fisr_fault_evt_type v);
    @(posedge mclk);
    fault_evt <= v;
    @(posedge mclk);
    fault_evt <= '0;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: run hung", $time);
      finish_test();
    end
  end

  initial
  begin
    tick(16);
    rstn <= 1'b1;
    rd(IDX_SEVERE, 32'h0);
    rd(IDX_SUMMARY, 32'h0);
    rd(IDX_LINK, 32'h0);
    rd(10'h3ff, 32'h0);
    // Severe bits, regulator shutdown and the live thermal bit
    regulator_enable_req <= 1'b1;
    tick(2);
    chk({31'h0, regulator_enable}, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      fpulse(7'h10 << i);
      // The trip edge launches the output; look one edge later
      tick(1);
      chk({31'h0, regulator_enable}, 32'h0);
      rd(IDX_SEVERE, 32'h1 << i);
      wr(IDX_SEVERE, 32'h0);
      rd(IDX_SEVERE, 32'h1 << i);
      wr(IDX_SEVERE, 32'hff);
      rd(IDX_SEVERE, 32'h0);
    end
    wr(IDX_SUMMARY, 32'h0f);
    @(posedge mclk);
    fault_evt <= 7'h10;
    rd(IDX_LIVE, 32'h1);
    fault_evt <= 7'h0;
    regulator_enable_req <= 1'b0;
    tick(2);
    rd(IDX_LIVE, 32'h0);
    rd(IDX_SEVERE, 32'h1);
    regulator_enable_req <= 1'b1;
    tick(3);
    chk({31'h0, regulator_enable}, 32'h0);
    wr(IDX_SEVERE, 32'h1);
    tick(2);
    chk({31'h0, regulator_enable}, 32'h1);
    // Latched summary bits, then the read-only mirrors
    wr(IDX_SUMMARY, 32'h0f);
    for (int i = 0; i < 4; i++)
    begin
      fpulse(7'h1 << i);
      rd(IDX_SUMMARY, (32'h2 << i) - 32'h1);
    end
    wr(IDX_SUMMARY, 32'hf0);
    rd(IDX_SUMMARY, 32'h0f);
    wr(IDX_SUMMARY, 32'h0f);
    rd(IDX_SUMMARY, 32'h0);
    wd_flags <= 3'h6;
    signal_monitor_fault_reg <= 8'h80;
    readback_fault_reg <= 8'h01;
    rd(IDX_SUMMARY, 32'he0);
    wr(IDX_SUMMARY, 32'hff);
    rd(IDX_SUMMARY, 32'he0);
    wd_flags <= 3'h1;
    signal_monitor_fault_reg <= 8'h0;
    rd(IDX_SUMMARY, 32'ha0);
    wd_flags <= 3'h0;
    readback_fault_reg <= 8'h0;
    rd(IDX_SUMMARY, 32'h0);
    // Link faults feed summary bit 4
    @(posedge mclk);
    link_evt <= 5'h1f;
    @(posedge mclk);
    link_evt <= 5'h0;
    rd(IDX_LINK, 32'hab);
    rd(IDX_SUMMARY, 32'h10);
    wr(IDX_LINK, 32'h0b);
    rd(IDX_LINK, 32'ha0);
    wr(IDX_LINK, 32'ha0);
    rd(IDX_SUMMARY, 32'h0);
    // A clear meeting a live source must not win
    @(posedge mclk);
    fault_evt <= 7'h08;
    wr(IDX_SUMMARY, 32'h08);
    rd(IDX_SUMMARY, 32'h08);
    fault_evt <= 7'h0;
    wr(IDX_SUMMARY, 32'h08);
    rd(IDX_SUMMARY, 32'h0);
    // Interrupt: every class fired so far, then mask and clear
    rd(IDX_EVT_STAT, 32'h3f);
    rd(IDX_EVT_STAT, 32'h0);
    wr(IDX_EVT_MASK, 32'h02);
    fpulse(7'h04);
    tick(2);
    chk({30'h0, interrupt_out_n, irq}, 32'h1);
    rd(IDX_EVT_STAT, 32'h02);
    tick(2);
    chk({30'h0, interrupt_out_n, irq}, 32'h0);
    wr(IDX_SUMMARY, 32'h04);
    fpulse(7'h40);
    tick(2);
    chk({30'h0, interrupt_out_n, irq}, 32'h2);
    finish_test();
  end
endmodule
`default_nettype wire
